// ===== hdl/alarm_and_power_mode_regs.sv
// alarm aggregation and low-power mode registers of the converter
// assumes the configuration port decoder on clk gives one-cycle read and write strobes;
// alarm sources are on clk except the serializer pll lock, which is synchronised here
`timescale 1ns/1ps
// Notes on behaviour
// R1: third power code: 0x00 low power, 0x04 high performance, reset 0x04.
// R2: fourth power code: 0x14 low power, 0x1B high performance, reset 0x1B.
// R3: second power code: 0x06 low power, 0x0F high performance.
// R4: software writes all power-mode registers together to one mode.
// R5: software calibrates after any power-mode change.
// R6: software clears calibration and link enables before power-mode writes.
// R7: low-power codes only allowed up to 1 GSPS sample rate.
// R8: summary bit 0 is one when any unmasked status alarm is set.
// R9: set mask bits exclude alarms from summary; mask resets to 0x3F.
// R10: summary alarm can be routed onto the status output pin.
// R11: status bit 5 sets on overflow or underflow of any active lane.
// R12: per-lane bit sets on its lane error; status bit 5 clear wipes all.
// R13: status bit 4 sets while serializer pll is unlocked.
// R14: 8b/10b: bit 3 sets while link enabled but not in data state.
// R15: 64b/66b: bit 3 sets at link start-up and on any realignment.
// R16: status bit 2 sets when sysref realigns the internal clocks.
// R17: status bit 0 sets when the two channel-pair dividers differ.
// R18: status bits are sticky, cleared by writing one, may re-set at once.
// R19: after power-on or soft reset the status register reads 0x3F.
// R20: software ignores alarms other than clock alarm while link disabled.
// R21: summary register bits 7:1 read as zero.
// R22: summary follows status and mask within one clock cycle.
// R23: reserved status bits 7:6 and 1 hold reset values, never in summary.
module alarm_and_power_mode_regs
   import alarm_regs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              soft_reset,
   input  wire logic [ADDR_W-1:0] cfg_addr,
   input  wire logic              cfg_wr,
   input  wire logic [DATA_W-1:0] cfg_wdata,
   input  wire logic              cfg_rd,
   output logic      [DATA_W-1:0] cfg_rdata,
   output logic                   cfg_rvalid,
   input  wire logic [LANES-1:0]  lane_active,
   input  wire logic [LANES-1:0]  lane_fifo_err,
   input  wire logic              pll_locked_async,
   input  wire logic              serial_link_enable,
   input  wire logic              data_transmit_state,
   input  wire logic              link_mode_64b66b,
   input  wire logic              link_realign,
   input  wire logic              sysref_realign,
   input  wire logic [DIV_W-1:0]  div_pair_ab,
   input  wire logic [DIV_W-1:0]  div_pair_cd,
   input  wire logic              status_select,
   input  wire logic              cal_status,
   output logic                   status_output_pin,
   output logic                   alarm_flag,
   output logic      [DATA_W-1:0] power_code_two,
   output logic      [DATA_W-1:0] power_code_three,
   output logic      [DATA_W-1:0] power_code_four,
   output logic                   low_power_all,
   output logic                   power_code_reserved
);
   ////////////////////////////////////////////////////////////////////////////
   // address decode for the write strobes; the read path decodes with its own case
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // a code is legal when it is one of its two documented values
   function automatic logic legal(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
      legal = (c == lo) || (c == hi);
   endfunction : legal

   ////////////////////////////////////////////////////////////////////////////
   // reset: power-on or soft reset both return the bank to defaults
   logic bank_rst;
   assign bank_rst = rst | soft_reset;

   ////////////////////////////////////////////////////////////////////////////
   // pll lock comes from the serializer pll, outside this clock domain
   logic pll_locked;

   level_sync #(
      .W     (1),
      .RST_V (1'b0)
   ) u_pll_sync (
      .clk (clk),
      .rst (bank_rst),
      .d   (pll_locked_async),
      .q   (pll_locked)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sticky status and per-lane flags
   sticky_if #(.W(8))     status_sif ();
   sticky_if #(.W(LANES)) lane_sif ();

   sticky_flags #(
      .W     (8),
      .RST_V (RST_ALARM_STICKY)                                               // [R19]
   ) u_status_flags (
      .clk (clk),
      .rst (bank_rst),
      .sif (status_sif)
   );

   sticky_flags #(
      .W     (LANES),
      .RST_V (RST_LANE_FIFO_ALARM)
   ) u_lane_flags (
      .clk (clk),
      .rst (bank_rst),
      .sif (lane_sif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // write strobes
   logic wr_two;
   logic wr_three;
   logic wr_four;
   logic wr_status;
   logic wr_mask;
   logic wr_lane;

   always_comb begin
      wr_two    = cfg_wr && hit(cfg_addr, OFS_POWER_MODE_TWO);
      wr_three  = cfg_wr && hit(cfg_addr, OFS_POWER_MODE_THREE);
      wr_four   = cfg_wr && hit(cfg_addr, OFS_POWER_MODE_FOUR);
      wr_status = cfg_wr && hit(cfg_addr, OFS_ALARM_STICKY);
      wr_mask   = cfg_wr && hit(cfg_addr, OFS_ALARM_MASK);
      wr_lane   = cfg_wr && hit(cfg_addr, OFS_LANE_FIFO_ALARM);
   end

   ////////////////////////////////////////////////////////////////////////////
   // alarm sources
   logic link_en_q_ff;
   logic nxt_link_en_q;
   logic link_start;
   logic fifo_evt;
   logic link_evt;

   always_comb begin
      nxt_link_en_q = serial_link_enable;
   end

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         link_en_q_ff <= 1'b0;
      end else begin
         link_en_q_ff <= nxt_link_en_q;
      end
   end

   always_comb begin
      link_start = serial_link_enable && !link_en_q_ff;
      fifo_evt   = |(lane_fifo_err & lane_active);                              // [R11]
      if (link_mode_64b66b) begin
         link_evt = link_start || link_realign;                              // [R15]
      end else begin
         link_evt = serial_link_enable && !data_transmit_state;              // [R14]
      end
   end

   always_comb begin
      status_sif.set              = ZERO_BYTE;
      status_sif.set[BIT_FIFO]    = fifo_evt;                                 // [R11]
      status_sif.set[BIT_PLL]     = !pll_locked;                              // [R13]
      status_sif.set[BIT_LINK]    = link_evt;
      status_sif.set[BIT_REALIGN] = sysref_realign;                           // [R16]
      status_sif.set[BIT_CLK]     = (div_pair_ab != div_pair_cd);             // [R17]
      // write-one clears, reserved bits are never cleared so they keep reset values
      status_sif.clr = wr_status ? (cfg_wdata & USED_ALARMS) : ZERO_BYTE;    // [R18] [R23]
   end

   always_comb begin
      lane_sif.set = lane_fifo_err;                                           // [R12]
      lane_sif.clr = ZERO_BYTE;
      if (wr_lane) begin
         lane_sif.clr = cfg_wdata;
      end
      // clearing the fifo status bit wipes every lane bit as well
      if (wr_status && cfg_wdata[BIT_FIFO]) begin
         lane_sif.clr = {LANES{1'b1}};                                        // [R12]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // writable configuration: power codes and mask
   logic [7:0] pm_two_ff;
   logic [7:0] pm_three_ff;
   logic [7:0] pm_four_ff;
   logic [7:0] mask_ff;
   logic [7:0] nxt_pm_two;
   logic [7:0] nxt_pm_three;
   logic [7:0] nxt_pm_four;
   logic [7:0] nxt_mask;

   // codes are stored as written; reserved codes are flagged rather than refused,
   // so software can read back exactly what it wrote
   always_comb begin
      nxt_pm_two   = wr_two   ? cfg_wdata : pm_two_ff;                        // [R3]
      nxt_pm_three = wr_three ? cfg_wdata : pm_three_ff;                      // [R1]
      nxt_pm_four  = wr_four  ? cfg_wdata : pm_four_ff;                       // [R2]
      nxt_mask     = wr_mask  ? cfg_wdata : mask_ff;
   end

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         pm_two_ff   <= RST_POWER_MODE_TWO;
         pm_three_ff <= RST_POWER_MODE_THREE;                                 // [R1]
         pm_four_ff  <= RST_POWER_MODE_FOUR;                                  // [R2]
         mask_ff     <= RST_ALARM_MASK;                                       // [R9]
      end else begin
         pm_two_ff   <= nxt_pm_two;
         pm_three_ff <= nxt_pm_three;
         pm_four_ff  <= nxt_pm_four;
         mask_ff     <= nxt_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power-mode decode; the core only goes low power when all codes agree
   logic low_all_ff;
   logic rsvd_ff;
   logic nxt_low_all;
   logic nxt_rsvd;

   always_comb begin
      nxt_low_all = (pm_two_ff == CODE_TWO_LOW)                               // [R3]
                 && (pm_three_ff == CODE_THREE_LOW)                           // [R1]
                 && (pm_four_ff == CODE_FOUR_LOW);                            // [R2]
      nxt_rsvd    = !legal(pm_two_ff, CODE_TWO_LOW, CODE_TWO_HIGH)
                 || !legal(pm_three_ff, CODE_THREE_LOW, CODE_THREE_HIGH)
                 || !legal(pm_four_ff, CODE_FOUR_LOW, CODE_FOUR_HIGH);
   end

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         low_all_ff <= 1'b0;
         rsvd_ff    <= 1'b0;
      end else begin
         low_all_ff <= nxt_low_all;
         rsvd_ff    <= nxt_rsvd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // summary alarm and pin routing
   logic summary_ff;
   logic pin_ff;
   logic nxt_summary;
   logic nxt_pin;

   // summary uses next-state flags and mask so it lands with the status change
   always_comb begin
      nxt_summary = |(((status_sif.flags & ~status_sif.clr) | status_sif.set)
                      & ~nxt_mask & USED_ALARMS);                             // [R8] [R9] [R22] [R23]
      nxt_pin     = status_select ? nxt_summary : cal_status;                 // [R10]
   end

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         summary_ff <= RST_ALARM_SUMMARY[0];
         pin_ff     <= 1'b0;
      end else begin
         summary_ff <= nxt_summary;
         pin_ff     <= nxt_pin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path, one cycle from strobe to data
   logic [7:0] rdata_ff;
   logic       rvalid_ff;
   logic [7:0] nxt_rdata;
   logic       nxt_rvalid;

   always_comb begin
      nxt_rdata  = ZERO_BYTE;
      nxt_rvalid = cfg_rd;
      if (cfg_rd) begin
         case (cfg_addr)
            OFS_POWER_MODE_TWO:   nxt_rdata = pm_two_ff;
            OFS_POWER_MODE_THREE: nxt_rdata = pm_three_ff;
            OFS_POWER_MODE_FOUR:  nxt_rdata = pm_four_ff;
            OFS_ALARM_SUMMARY:    nxt_rdata = {7'h00, summary_ff};            // [R21]
            OFS_ALARM_STICKY:     nxt_rdata = status_sif.flags & RST_ALARM_STICKY;
            OFS_ALARM_MASK:       nxt_rdata = mask_ff;
            OFS_LANE_FIFO_ALARM:  nxt_rdata = lane_sif.flags;
            default:              nxt_rdata = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (bank_rst) begin
         rdata_ff  <= ZERO_BYTE;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   assign cfg_rdata           = rdata_ff;
   assign cfg_rvalid          = rvalid_ff;
   assign alarm_flag          = summary_ff;
   assign status_output_pin   = pin_ff;
   assign power_code_two      = pm_two_ff;
   assign power_code_three    = pm_three_ff;
   assign power_code_four     = pm_four_ff;
   assign low_power_all       = low_all_ff;
   assign power_code_reserved = rsvd_ff;
endmodule : alarm_and_power_mode_regs

// ===== pkg/alarm_regs_pkg.sv
// register map, reset values, field positions and codes of the alarm and power-mode bank
// assumes 12-bit configuration-port addresses and 8-bit register data
package alarm_regs_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned LANES  = 8;
   localparam int unsigned DIV_W  = 4;

   // register offsets
   localparam logic [11:0] OFS_POWER_MODE_TWO   = 12'h029a;
   localparam logic [11:0] OFS_POWER_MODE_THREE = 12'h029b;
   localparam logic [11:0] OFS_POWER_MODE_FOUR  = 12'h029c;
   localparam logic [11:0] OFS_ALARM_SUMMARY    = 12'h02c0;
   localparam logic [11:0] OFS_ALARM_STICKY     = 12'h02c1;
   localparam logic [11:0] OFS_ALARM_MASK       = 12'h02c2;
   localparam logic [11:0] OFS_LANE_FIFO_ALARM  = 12'h02c4;

   // reset values
   localparam logic [7:0] RST_POWER_MODE_TWO   = 8'h0f;
   localparam logic [7:0] RST_POWER_MODE_THREE = 8'h04;
   localparam logic [7:0] RST_POWER_MODE_FOUR  = 8'h1b;
   localparam logic [7:0] RST_ALARM_SUMMARY    = 8'h00;
   localparam logic [7:0] RST_ALARM_STICKY     = 8'h3f;
   localparam logic [7:0] RST_ALARM_MASK       = 8'h3f;
   localparam logic [7:0] RST_LANE_FIFO_ALARM  = 8'hff;

   // power codes
   localparam logic [7:0] CODE_TWO_LOW    = 8'h06;
   localparam logic [7:0] CODE_TWO_HIGH   = 8'h0f;
   localparam logic [7:0] CODE_THREE_LOW  = 8'h00;
   localparam logic [7:0] CODE_THREE_HIGH = 8'h04;
   localparam logic [7:0] CODE_FOUR_LOW   = 8'h14;
   localparam logic [7:0] CODE_FOUR_HIGH  = 8'h1b;

   // sticky status bit positions
   localparam int unsigned BIT_FIFO    = 5;
   localparam int unsigned BIT_PLL     = 4;
   localparam int unsigned BIT_LINK    = 3;
   localparam int unsigned BIT_REALIGN = 2;
   localparam int unsigned BIT_RSVD    = 1;
   localparam int unsigned BIT_CLK     = 0;
   // bits that take part in the summary
   localparam logic [7:0] USED_ALARMS  = 8'h3d;
   localparam logic [7:0] ZERO_BYTE    = 8'h00;
endpackage : alarm_regs_pkg

// ===== pkg/sticky_if.sv
// set/clear/state bundle between the register bank and a sticky flag vector
// assumes one clock domain on both sides
`timescale 1ns/1ps
interface sticky_if #(parameter int unsigned W = 8);
   logic [W-1:0] set;
   logic [W-1:0] clr;
   logic [W-1:0] flags;
   modport owner (input set, input clr, output flags);
   modport user  (output set, output clr, input flags);
endinterface : sticky_if

// ===== hdl/level_sync.sv
// two flip-flop synchroniser for levels from outside the clock domain
// assumes each bit changes slowly compared with clk
`timescale 1ns/1ps
module level_sync #(
   parameter int unsigned W      = 1,
   parameter logic [W-1:0] RST_V = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_q;

   // first stage feeds the second stage only
   always_comb begin
      nxt_meta = d;
      nxt_q    = meta_ff;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= RST_V;
         q_ff    <= RST_V;
      end else begin
         meta_ff <= nxt_meta;
         q_ff    <= nxt_q;
      end
   end

   assign q = q_ff;
endmodule : level_sync

// ===== hdl/sticky_flags.sv
// vector of sticky flags, set by hardware events, cleared by write-one
// assumes set and clr come from logic on clk
`timescale 1ns/1ps
module sticky_flags #(
   parameter int unsigned W      = 8,
   parameter logic [W-1:0] RST_V = '0
) (
   input  wire logic clk,
   input  wire logic rst,
   sticky_if.owner   sif
);
   logic [W-1:0] flags_ff;
   logic [W-1:0] nxt_flags;

   // set wins over a clear in the same cycle, so no event is lost
   always_comb begin
      nxt_flags = (flags_ff & ~sif.clr) | sif.set;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flags_ff <= RST_V;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   assign sif.flags = flags_ff;
endmodule : sticky_flags

// ===== bench/alarm_and_power_mode_regs_asserts.sv
// concurrent checks for the alarm and power-mode register bank
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module alarm_regs_asserts
   import alarm_regs_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              soft_reset,
   input wire logic [ADDR_W-1:0] cfg_addr,
   input wire logic              cfg_wr,
   input wire logic [DATA_W-1:0] cfg_wdata,
   input wire logic              cfg_rd,
   input wire logic [DATA_W-1:0] cfg_rdata,
   input wire logic              cfg_rvalid,
   input wire logic [LANES-1:0]  lane_active,
   input wire logic [LANES-1:0]  lane_fifo_err,
   input wire logic              pll_locked_async,
   input wire logic              serial_link_enable,
   input wire logic              data_transmit_state,
   input wire logic              link_mode_64b66b,
   input wire logic              link_realign,
   input wire logic              sysref_realign,
   input wire logic [DIV_W-1:0]  div_pair_ab,
   input wire logic [DIV_W-1:0]  div_pair_cd,
   input wire logic              status_select,
   input wire logic              status_output_pin,
   input wire logic              alarm_flag
);
////////////////////////////////////////
// shadow of the mask: the summary depends on it but it is not a port
logic [7:0] mask_ff;
logic [7:0] nxt_mask;
logic       clr_wr;
always_comb begin
   nxt_mask = mask_ff;
   if (cfg_wr && cfg_addr == OFS_ALARM_MASK) begin
      nxt_mask = cfg_wdata;
   end
end
always_ff @(posedge clk) begin
   if (rst || soft_reset) begin
      mask_ff <= RST_ALARM_MASK;
   end else begin
      mask_ff <= nxt_mask;
   end
end
assign clr_wr = cfg_wr && (cfg_addr == OFS_ALARM_STICKY || cfg_addr == OFS_ALARM_MASK);
////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (rst || soft_reset);
// the lock input passes two sync stages before it can set the alarm
sequence pll_lost;
   (!pll_locked_async)[*3];
endsequence
sequence link_not_ready;
   serial_link_enable && !data_transmit_state && !link_mode_64b66b;
endsequence
summ_rsvd_zero_a: assert property (cfg_rd && cfg_addr == OFS_ALARM_SUMMARY |=> cfg_rvalid && cfg_rdata[7:1] == 7'h00)
   else $error("summary reserved bits not zero");
mask_excludes_a: assert property ((mask_ff & USED_ALARMS) == USED_ALARMS |-> !alarm_flag)
   else $error("summary set with all alarms masked");
sysref_sets_a: assert property (sysref_realign && !nxt_mask[BIT_REALIGN] |=> alarm_flag)
   else $error("sysref realign did not raise summary");
pll_sets_a: assert property (pll_lost ##0 !nxt_mask[BIT_PLL] |=> alarm_flag)
   else $error("pll unlock did not raise summary");
div_sets_a: assert property (div_pair_ab != div_pair_cd && !nxt_mask[BIT_CLK] |=> alarm_flag)
   else $error("divider mismatch did not raise summary");
lane_sets_a: assert property ((|(lane_active & lane_fifo_err)) && !nxt_mask[BIT_FIFO] |=> alarm_flag)
   else $error("lane fifo error did not raise summary");
link8_sets_a: assert property (link_not_ready ##0 !nxt_mask[BIT_LINK] |=> alarm_flag)
   else $error("link not ready did not raise summary");
link64_sets_a: assert property (link_mode_64b66b && (link_realign || $rose(serial_link_enable)) && !nxt_mask[BIT_LINK] |=> alarm_flag)
   else $error("64b66b link event did not raise summary");
sticky_hold_a: assert property (alarm_flag && !clr_wr |=> alarm_flag)
   else $error("summary dropped without a clear");
pin_route_a: assert property ($past(status_select) && !$past(rst) && !$past(soft_reset) |-> status_output_pin == alarm_flag)
   else $error("status pin does not follow summary");
endmodule : alarm_regs_asserts

// ===== bench/alarm_and_power_mode_regs_tb.sv
// self-checking bench for the alarm and power-mode register bank
// assumes the design and package are compiled first
`timescale 1ns/1ps
module alarm_and_power_mode_regs_tb;
   import alarm_regs_pkg::*;
logic clk = 0, rst = 1, soft_reset = 0, cfg_wr = 0, cfg_rd = 0, cfg_rvalid;
logic [11:0] cfg_addr = 12'h0000;
logic [7:0] cfg_wdata = 8'h00, cfg_rdata, lane_active = 8'hff, lane_fifo_err = 8'h00;
logic pll_locked_async = 1, serial_link_enable = 0, data_transmit_state = 1, link_mode_64b66b = 0;
logic link_realign = 0, sysref_realign = 0, status_select = 1, cal_status = 0;
logic [3:0] div_pair_ab = 4'h0, div_pair_cd = 4'h0;
logic status_output_pin, alarm_flag, low_power_all, power_code_reserved;
logic [7:0] power_code_two, power_code_three, power_code_four;
int errors = 0, cmp_count = 0;
logic [11:0] ofs [3] = '{OFS_POWER_MODE_TWO, OFS_POWER_MODE_THREE, OFS_POWER_MODE_FOUR};
logic [7:0] lo [3] = '{CODE_TWO_LOW, CODE_THREE_LOW, CODE_FOUR_LOW};
logic [7:0] hi [3] = '{CODE_TWO_HIGH, CODE_THREE_HIGH, CODE_FOUR_HIGH};
int bits [5] = '{0, 2, 3, 4, 5};
alarm_and_power_mode_regs dut (.*);
always #5 clk = ~clk;
////////////////////////////////////////
task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
   cmp_count++;
   if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
   end
endtask : chk
task automatic wr(input logic [11:0] a, input logic [7:0] d);
   @(posedge clk);
   cfg_addr <= a;
   cfg_wdata <= d;
   cfg_wr <= 1'b1;
   @(posedge clk);
   cfg_wr <= 1'b0;
endtask : wr
task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
   @(posedge clk);
   cfg_addr <= a;
   cfg_rd <= 1'b1;
   @(posedge clk);
   cfg_rd <= 1'b0;
   #1;
   chk(nm, exp, (cfg_rvalid === 1'b1) ? cfg_rdata : 8'hxx);
endtask : rd
// raise or drop one alarm source
task automatic cond(input int k, input logic on);
   case (k)
      0: div_pair_cd <= on ? 4'h5 : 4'h0;
      2: sysref_realign <= on;
      3: data_transmit_state <= !on;
      4: pll_locked_async <= !on;
      default: lane_fifo_err <= on ? 8'h08 : 8'h00;
   endcase
endtask : cond
task automatic fire(input int k);
   @(posedge clk);
   cond(k, 1'b1);
   repeat (3) @(posedge clk);
   cond(k, 1'b0);
   repeat (3) @(posedge clk);
endtask : fire
////////////////////////////////////////
task automatic t_power();
   foreach (ofs[i]) rd(ofs[i], hi[i], "power reset");
   for (int m = 0; m < 2; m++) begin
      foreach (ofs[i]) wr(ofs[i], m ? hi[i] : lo[i]);
      foreach (ofs[i]) rd(ofs[i], m ? hi[i] : lo[i], "power code");
      chk("low_power_all", {7'h00, m == 0}, {7'h00, low_power_all});
      chk("power_code_two", m ? hi[0] : lo[0], power_code_two);
      chk("power_code_three", m ? hi[1] : lo[1], power_code_three);
      chk("power_code_four", m ? hi[2] : lo[2], power_code_four);
   end
   wr(OFS_POWER_MODE_FOUR, 8'h55);
   rd(OFS_POWER_MODE_FOUR, 8'h55, "reserved code");
   chk("power_code_reserved", 8'h01, {7'h00, power_code_reserved});
   wr(OFS_POWER_MODE_FOUR, CODE_FOUR_HIGH);
endtask : t_power
task automatic t_events();
   serial_link_enable <= 1'b1;
   wr(OFS_ALARM_MASK, 8'h00);
   wr(OFS_ALARM_STICKY, 8'h3f);
   rd(OFS_ALARM_STICKY, 8'h02, "sticky cleared");
   rd(OFS_LANE_FIFO_ALARM, 8'h00, "lanes cleared");
   chk("flag idle", 8'h00, {7'h00, alarm_flag});
   foreach (bits[i]) begin
      fire(bits[i]);
      rd(OFS_ALARM_STICKY, 8'h02 | (8'h01 << bits[i]), "sticky set");
      rd(OFS_ALARM_SUMMARY, 8'h01, "summary set");
      chk("pin alarm", 8'h01, {7'h00, status_output_pin});
      if (bits[i] == 5) rd(OFS_LANE_FIFO_ALARM, 8'h08, "lane set");
      wr(OFS_ALARM_STICKY, 8'h01 << bits[i]);
      rd(OFS_ALARM_STICKY, 8'h02, "sticky w1c");
      chk("flag cleared", 8'h00, {7'h00, alarm_flag});
   end
   rd(OFS_LANE_FIFO_ALARM, 8'h00, "lanes wiped");
   // an error on an inactive lane marks its lane bit but not the status bit
   @(posedge clk);
   lane_active <= 8'hf7;
   fire(5);
   rd(OFS_ALARM_STICKY, 8'h02, "inactive lane");
   chk("inactive flag", 8'h00, {7'h00, alarm_flag});
   rd(OFS_LANE_FIFO_ALARM, 8'h08, "inactive lane bit");
   wr(OFS_LANE_FIFO_ALARM, 8'h08);
   lane_active <= 8'hff;
   rd(OFS_LANE_FIFO_ALARM, 8'h00, "lane w1c");
endtask : t_events
task automatic t_mask_persist();
   wr(OFS_ALARM_MASK, 8'h3f);
   fire(2);
   rd(OFS_ALARM_STICKY, 8'h06, "masked sticky");
   chk("masked flag", 8'h00, {7'h00, alarm_flag});
   wr(OFS_ALARM_STICKY, 8'h04);
   cond(0, 1'b1);
   repeat (2) @(posedge clk);
   wr(OFS_ALARM_STICKY, 8'h01);
   rd(OFS_ALARM_STICKY, 8'h03, "persisting set");
   @(posedge clk);
   cond(0, 1'b0);
   wr(OFS_ALARM_STICKY, 8'h01);
endtask : t_mask_persist
task automatic t_link64();
   link_mode_64b66b <= 1'b1;
   serial_link_enable <= 1'b0;
   // unmasked, so the summary and its assertions see the link events
   wr(OFS_ALARM_MASK, 8'h00);
   wr(OFS_ALARM_STICKY, 8'h08);
   serial_link_enable <= 1'b1;
   rd(OFS_ALARM_STICKY, 8'h0a, "link start");
   chk("link flag", 8'h01, {7'h00, alarm_flag});
   wr(OFS_ALARM_STICKY, 8'h08);
   rd(OFS_ALARM_STICKY, 8'h02, "link quiet");
   @(posedge clk);
   link_realign <= 1'b1;
   @(posedge clk);
   link_realign <= 1'b0;
   rd(OFS_ALARM_STICKY, 8'h0a, "link realign");
   wr(OFS_ALARM_STICKY, 8'h08);
   link_mode_64b66b <= 1'b0;
endtask : t_link64
task automatic t_bus_pin();
   rd(12'h02c3, 8'h00, "unmapped");
   wr(OFS_ALARM_SUMMARY, 8'hff);
   rd(OFS_ALARM_SUMMARY, 8'h00, "summary ro");
   wr(OFS_ALARM_STICKY, 8'hc2);
   rd(OFS_ALARM_STICKY, 8'h02, "reserved status");
   @(posedge clk);
   status_select <= 1'b0;
   cal_status <= 1'b1;
   repeat (3) @(posedge clk);
   chk("pin cal", 8'h01, {7'h00, status_output_pin});
endtask : t_bus_pin
task automatic t_soft();
   @(posedge clk);
   soft_reset <= 1'b1;
   @(posedge clk);
   soft_reset <= 1'b0;
   rd(OFS_ALARM_STICKY, RST_ALARM_STICKY, "soft status");
   rd(OFS_ALARM_MASK, 8'h3f, "soft mask");
   rd(OFS_ALARM_SUMMARY, 8'h00, "soft summary");
endtask : t_soft
////////////////////////////////////////
task automatic print_verdict();
   if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
   else $display("SIMULATION FAILED");
   $finish;
endtask : print_verdict
// far more than the scenarios need; only a hang reaches it
initial begin
   repeat (20000) @(posedge clk);
   errors++;
   print_verdict();
end
initial begin
   repeat (16) @(posedge clk);
   rst <= 1'b0;
   t_power();
   t_events();
   t_mask_persist();
   t_link64();
   t_bus_pin();
   t_soft();
   print_verdict();
end
endmodule : alarm_and_power_mode_regs_tb
bind alarm_and_power_mode_regs alarm_regs_asserts chk_i (.*);
